// [hdl/smbc_defs.svh]
// constants of the two-wire bus control block: offsets, fields, counts
// assumes an 8-bit register port with a 2-bit word address
//
// Contract
// RULE1: with scl timeout enabled, timeout timer reloads while scl high
// RULE2: software programs timeout timer for 25 ms and resets bus
// RULE3: bus is free after scl and sda high over 10 source periods
// RULE4: two-bit field picks timer 0, 1, 2 high or 2 low overflow
// RULE5: controller and transmit state read as top two control bits
// RULE6: start and stop flags show conditions seen since last interrupt
// RULE7: start request enters controller mode, start when free, not cleared
// RULE8: stop request in controller mode ends transfer after next ack
// RULE9: start and stop requests together give stop then start
// RULE10: ack bit sets outgoing level as receiver, shows received as sender
// RULE11: acknowledge-needed flag set each time a byte is received
// RULE12: software writes ack bit before clearing the interrupt flag
// RULE13: interrupt cleared without ack write sends a nack
// RULE14: sda follows a written ack at once, scl low until cleared
// RULE15: nacked target address ignores target events until next start
// RULE16: arbitration loss while sending sets the arbitration flag
// RULE17: arbitration flag clears whenever interrupt flag is cleared
// RULE18: interrupt flag set at transfer start, end, bytes, arbitration loss
// RULE19: scl held low while the interrupt flag is set; the code releases scl when the flag is set by arbitration loss or a seen stop
// RULE20: configuration bit enables scl low timeout detection
// RULE21: software clears interrupt flag by writing zero, releasing bus
`ifndef SMBC_DEFS_SVH
`define SMBC_DEFS_SVH

// ==========================================================
// register map
`define SMBC_AW          2
`define SMBC_ADDR_CFG    2'h0
`define SMBC_ADDR_CTRL   2'h1
`define SMBC_ADDR_DATA   2'h2

// ==========================================================
// configuration fields
`define SMBC_CFG_TOE     3
`define SMBC_CFG_FTE     2
`define SMBC_CFG_CS_HI   1
`define SMBC_CFG_CS_LO   0
`define SMBC_CFG_RST     4'h0

// ==========================================================
// control fields
`define SMBC_CTL_STA     5
`define SMBC_CTL_STO     4
`define SMBC_CTL_ACK     1
`define SMBC_CTL_SI      0
`define SMBC_CTRL_RST    8'h00
`define SMBC_DATA_RST    8'h00

// ==========================================================
// bit-rate sources and counts
`define SMBC_SRC_T0      2'h0
`define SMBC_SRC_T1      2'h1
`define SMBC_SRC_T2H     2'h2
`define SMBC_SRC_T2L     2'h3
`define SMBC_FREE_PERIODS 4'ha
`define SMBC_ACK_BIT     4'h8
`define SMBC_LAST_DATA   4'h7

`endif

// [hdl/smbc_pkg.sv]
// types of the two-wire bus control block
// assumes nothing of its surroundings
package smbc_pkg;

  typedef enum {
    ST_IDLE,
    ST_START,
    ST_LOW,
    ST_HIGH,
    ST_HOLD,
    ST_STOP,
    ST_RSTART
  } smbc_state_type;

  typedef struct packed {
    logic scl;
    logic sda;
  } smbc_pins_type;

  typedef struct packed {
    logic master;
    logic tx;
    logic begin_request_flag;
    logic halt_request_flag;
    logic acknowledge_needed_flag;
    logic arbitration_fail_flag;
    logic ack;
    logic si;
  } smbc_ctrl_type;

endpackage

// [hdl/smbc_core.sv]
// two-wire bus control block: timeouts, clock source, control flags
// assumes pins and timer overflow pulses synchronous to clk_sys
`timescale 1ns/1ps
`include "smbc_defs.svh"

module smbc_core
  import smbc_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  // register port
  input  wire logic [`SMBC_AW-1:0]   reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  // timer overflow pulses: t0, t1, t2 high, t2 low
  input  wire logic [3:0]            tmr_ovf,
  // scl low timeout timer control
  output logic                       timeout_reload,
  // open-drain bus pins
  input  wire smbc_pins_type         pin_in,
  output smbc_pins_type              pin_out,
  output smbc_pins_type              pin_oe_n
);

  // ==========================================================
  // decoding helpers
  function automatic logic pick_tick(input logic [1:0] sel,
                                     input logic [3:0] ovf);
    logic t;
    t = 1'b0;
    case (sel)
      `SMBC_SRC_T0:  t = ovf[0];
      `SMBC_SRC_T1:  t = ovf[1];
      `SMBC_SRC_T2H: t = ovf[2];
      `SMBC_SRC_T2L: t = ovf[3];
      default:       t = 1'b0;
    endcase
    return t;
  endfunction

  // ==========================================================
  // state
  smbc_state_type state_reg,   state_next;
  smbc_ctrl_type  ctrl_reg,    ctrl_next;
  logic [3:0]     cfg_reg,     cfg_next;
  logic [7:0]     data_reg,    data_next;
  logic [7:0]     shift_reg,   shift_next;
  logic [3:0]     bitcnt_reg,  bitcnt_next;
  logic [3:0]     freecnt_reg, freecnt_next;
  logic           stage_reg,   stage_next;
  logic           scl_drv_reg, scl_drv_next;
  logic           sda_drv_reg, sda_drv_next;
  logic           sta_seen_reg, sta_seen_next;
  logic           sto_seen_reg, sto_seen_next;
  logic           ack_wr_reg,  ack_wr_next;
  logic           addr_ph_reg, addr_ph_next;
  logic           ignore_reg,  ignore_next;
  logic           busy_reg,    busy_next;
  logic           scl_q_reg;
  logic           sda_q_reg;
  logic [7:0]     rdata_reg;
  logic           reload_reg;

  // ==========================================================
  // decode
  wire        wr_cfg   = reg_wr & (reg_addr == `SMBC_ADDR_CFG);
  wire        wr_ctrl  = reg_wr & (reg_addr == `SMBC_ADDR_CTRL);
  wire        wr_data  = reg_wr & (reg_addr == `SMBC_ADDR_DATA);
  // RULE21: clear by zero write
  wire        si_clr   = wr_ctrl & ~reg_wdata[`SMBC_CTL_SI] & ctrl_reg.si;
  // RULE4: source select
  wire        tick     = pick_tick(cfg_reg[1:0], tmr_ovf);
  wire        scl_rise = pin_in.scl & ~scl_q_reg;
  wire        scl_fall = ~pin_in.scl & scl_q_reg;
  wire        start_det = pin_in.scl & scl_q_reg & sda_q_reg & ~pin_in.sda;
  wire        stop_det  = pin_in.scl & scl_q_reg & ~sda_q_reg & pin_in.sda;
  // RULE13: nack unless written
  wire        ack_out  = ack_wr_reg & ctrl_reg.ack;
  wire        bus_high = pin_in.scl & pin_in.sda;
  // RULE3: strictly more than ten periods
  wire        free_hit = cfg_reg[`SMBC_CFG_FTE] &
                         (freecnt_reg > `SMBC_FREE_PERIODS);
  // RULE5: role flags on top
  wire [7:0]  ctrl_view = {ctrl_reg.master, ctrl_reg.tx,
                           ctrl_reg.begin_request_flag | sta_seen_reg,
                           ctrl_reg.halt_request_flag | sto_seen_reg,
                           ctrl_reg.acknowledge_needed_flag, ctrl_reg.arbitration_fail_flag,
                           ctrl_reg.ack, ctrl_reg.si};
  wire [7:0]  rd_mux =
    (reg_addr == `SMBC_ADDR_CFG)  ? {4'h0, cfg_reg} :
    (reg_addr == `SMBC_ADDR_CTRL) ? ctrl_view :
    (reg_addr == `SMBC_ADDR_DATA) ? shift_reg : 8'h00;

  // ==========================================================
  // next state
  always_comb
  begin
    state_next    = state_reg;
    ctrl_next     = ctrl_reg;
    cfg_next      = cfg_reg;
    data_next     = data_reg;
    shift_next    = shift_reg;
    bitcnt_next   = bitcnt_reg;
    freecnt_next  = freecnt_reg;
    stage_next    = stage_reg;
    scl_drv_next  = scl_drv_reg;
    sda_drv_next  = sda_drv_reg;
    sta_seen_next = sta_seen_reg;
    sto_seen_next = sto_seen_reg;
    ack_wr_next   = ack_wr_reg;
    addr_ph_next  = addr_ph_reg;
    ignore_next   = ignore_reg;
    busy_next     = busy_reg;

    // software writes
    if (wr_cfg)
      cfg_next = reg_wdata[3:0];
    if (wr_data)
      data_next = reg_wdata;
    if (wr_ctrl)
    begin
      ctrl_next.begin_request_flag = reg_wdata[`SMBC_CTL_STA];
      ctrl_next.halt_request_flag = reg_wdata[`SMBC_CTL_STO];
      // RULE10: outgoing ack level
      ctrl_next.ack = reg_wdata[`SMBC_CTL_ACK];
      ctrl_next.si  = reg_wdata[`SMBC_CTL_SI] | ctrl_reg.si;
      ack_wr_next   = 1'b1;
    end
    if (si_clr)
    begin
      ctrl_next.si      = 1'b0;
      // RULE17: cleared with interrupt
      ctrl_next.arbitration_fail_flag = 1'b0;
      sta_seen_next     = 1'b0;
      sto_seen_next     = 1'b0;
    end

    // RULE6: conditions seen since interrupt
    if (start_det)
      sta_seen_next = 1'b1;
    if (stop_det)
      sto_seen_next = 1'b1;

    // RULE3: free timeout counting
    if (!bus_high)
      freecnt_next = 4'h0;
    else if (tick && !free_hit)
      freecnt_next = freecnt_reg + 4'h1;
    if (start_det)
      busy_next = 1'b1;
    else if (stop_det || free_hit)
      busy_next = 1'b0;

    case (state_reg)
      ST_IDLE:
      begin
        // RULE7: start once bus free
        if (ctrl_reg.begin_request_flag && !busy_reg)
        begin
          state_next   = ST_START;
          sda_drv_next = 1'b1;
        end
      end
      ST_START:
      begin
        if (tick)
        begin
          // RULE18: start of transfer
          scl_drv_next     = 1'b1;
          state_next       = ST_HOLD;
          ctrl_next.si     = 1'b1;
          ctrl_next.master = 1'b1;
          ctrl_next.tx     = 1'b1;
          addr_ph_next     = 1'b1;
        end
      end
      ST_LOW:
      begin
        scl_drv_next = ctrl_reg.master & scl_drv_reg & ~tick;
        if (scl_rise)
        begin
          state_next = ST_HIGH;
          if (bitcnt_reg != `SMBC_ACK_BIT)
          begin
            shift_next = {shift_reg[6:0], pin_in.sda};
            // RULE16: lost while sending
            if (ctrl_reg.tx && !sda_drv_reg && !pin_in.sda)
            begin
              ctrl_next.arbitration_fail_flag = 1'b1;
              ctrl_next.si      = 1'b1;
              ctrl_next.master  = 1'b0;
              sda_drv_next      = 1'b0;
              scl_drv_next      = 1'b0;
              state_next        = ST_IDLE;
            end
          end
          else if (ctrl_reg.tx)
            // RULE10: received ack level
            ctrl_next.ack = ~pin_in.sda;
        end
      end
      ST_HIGH:
      begin
        if (ctrl_reg.master ? tick : scl_fall)
        begin
          scl_drv_next = ctrl_reg.master;
          state_next   = ST_LOW;
          if (bitcnt_reg != `SMBC_ACK_BIT)
          begin
            bitcnt_next  = bitcnt_reg + 4'h1;
            sda_drv_next = 1'b0;
            if (ctrl_reg.tx && bitcnt_reg != `SMBC_LAST_DATA)
              sda_drv_next = ~shift_reg[7];
            if (!ctrl_reg.tx && bitcnt_reg == `SMBC_LAST_DATA)
            begin
              // RULE11: byte received
              ctrl_next.acknowledge_needed_flag = 1'b1;
              ctrl_next.si    = 1'b1;
              ack_wr_next     = 1'b0;
              scl_drv_next    = 1'b1;
              state_next      = ST_HOLD;
            end
          end
          else
          begin
            bitcnt_next  = 4'h0;
            sda_drv_next = 1'b0;
            if (addr_ph_reg && !ctrl_reg.master)
            begin
              addr_ph_next = 1'b0;
              if (!sda_drv_reg)
              begin
                // RULE15: nacked address
                ignore_next = 1'b1;
                state_next  = ST_IDLE;
              end
              else if (shift_reg[0])
              begin
                ctrl_next.tx = 1'b1;
                ctrl_next.si = 1'b1;
                scl_drv_next = 1'b1;
                state_next   = ST_HOLD;
              end
            end
            else if (addr_ph_reg || ctrl_reg.tx)
            begin
              addr_ph_next = 1'b0;
              if (addr_ph_reg)
                ctrl_next.tx = ~shift_reg[0];
              if (!ctrl_reg.master && !ctrl_reg.ack)
                state_next = ST_IDLE;
              else
              begin
                // RULE18: after byte frame
                ctrl_next.si = 1'b1;
                scl_drv_next = 1'b1;
                state_next   = ST_HOLD;
              end
            end
            else if (ctrl_reg.master && ctrl_reg.halt_request_flag)
            begin
              // RULE8: stop after ack
              sda_drv_next = 1'b1;
              stage_next   = 1'b0;
              state_next   = ST_STOP;
            end
            else if (ctrl_reg.master && ctrl_reg.begin_request_flag)
            begin
              stage_next = 1'b0;
              state_next = ST_RSTART;
            end
          end
        end
      end
      ST_HOLD:
      begin
        // RULE19: stall while flag set
        scl_drv_next = 1'b1;
        // RULE14: ack level at once
        if (ctrl_reg.acknowledge_needed_flag)
          sda_drv_next = ack_out;
        if (si_clr)
        begin
          state_next = ST_LOW;
          if (ctrl_reg.acknowledge_needed_flag)
            ctrl_next.acknowledge_needed_flag = 1'b0;
          else if (ctrl_reg.master && ctrl_next.halt_request_flag)
          begin
            // RULE9: stop before start
            sda_drv_next = 1'b1;
            stage_next   = 1'b0;
            state_next   = ST_STOP;
          end
          else if (ctrl_reg.master && ctrl_next.begin_request_flag)
          begin
            sda_drv_next = 1'b0;
            stage_next   = 1'b0;
            state_next   = ST_RSTART;
          end
          else
          begin
            bitcnt_next  = 4'h0;
            shift_next   = data_reg;
            sda_drv_next = ctrl_reg.tx & ~data_reg[7];
          end
        end
      end
      ST_STOP:
      begin
        if (tick && !stage_reg)
        begin
          scl_drv_next = 1'b0;
          stage_next   = 1'b1;
        end
        else if (tick)
        begin
          sda_drv_next     = 1'b0;
          ctrl_next.master = 1'b0;
          ctrl_next.halt_request_flag    = 1'b0;
          state_next       = ST_IDLE;
        end
      end
      ST_RSTART:
      begin
        sda_drv_next = 1'b0;
        if (tick && !stage_reg)
        begin
          scl_drv_next = 1'b0;
          stage_next   = 1'b1;
        end
        else if (tick)
        begin
          sda_drv_next = 1'b1;
          state_next   = ST_START;
        end
      end
      default:
        state_next = ST_IDLE;
    endcase

    // target side reacts to bus conditions
    if (!ctrl_reg.master && state_reg != ST_START)
    begin
      if (start_det)
      begin
        // RULE15: start ends ignoring
        ignore_next  = 1'b0;
        addr_ph_next = 1'b1;
        ctrl_next.tx = 1'b0;
        bitcnt_next  = 4'h0;
        sda_drv_next = 1'b0;
        scl_drv_next = 1'b0;
        state_next   = ST_LOW;
      end
      else if (stop_det && state_reg != ST_IDLE)
      begin
        // RULE18: end of transfer
        ctrl_next.si = 1'b1;
        sda_drv_next = 1'b0;
        scl_drv_next = 1'b0;
        state_next   = ST_IDLE;
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_reg    <= ST_IDLE;
      ctrl_reg     <= smbc_ctrl_type'(`SMBC_CTRL_RST);
      cfg_reg      <= `SMBC_CFG_RST;
      data_reg     <= `SMBC_DATA_RST;
      shift_reg    <= 8'h00;
      bitcnt_reg   <= 4'h0;
      freecnt_reg  <= 4'h0;
      stage_reg    <= 1'b0;
      scl_drv_reg  <= 1'b0;
      sda_drv_reg  <= 1'b0;
      sta_seen_reg <= 1'b0;
      sto_seen_reg <= 1'b0;
      ack_wr_reg   <= 1'b0;
      addr_ph_reg  <= 1'b0;
      ignore_reg   <= 1'b0;
      // bus state unknown after reset: busy until seen free
      busy_reg     <= 1'b1;
    end
    else
    begin
      state_reg    <= state_next;
      ctrl_reg     <= ctrl_next;
      cfg_reg      <= cfg_next;
      data_reg     <= data_next;
      shift_reg    <= shift_next;
      bitcnt_reg   <= bitcnt_next;
      freecnt_reg  <= freecnt_next;
      stage_reg    <= stage_next;
      scl_drv_reg  <= scl_drv_next;
      sda_drv_reg  <= sda_drv_next;
      sta_seen_reg <= sta_seen_next;
      sto_seen_reg <= sto_seen_next;
      ack_wr_reg   <= ack_wr_next;
      addr_ph_reg  <= addr_ph_next;
      ignore_reg   <= ignore_next;
      busy_reg     <= busy_next;
    end
  end

  // ==========================================================
  // pin sampling, read port, outputs
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      scl_q_reg  <= 1'b1;
      sda_q_reg  <= 1'b1;
      rdata_reg  <= 8'h00;
      reload_reg <= 1'b0;
    end
    else
    begin
      scl_q_reg  <= pin_in.scl;
      sda_q_reg  <= pin_in.sda;
      rdata_reg  <= reg_rd ? rd_mux : 8'h00;
      // RULE1: reload while scl high
      // RULE20: gated by enable
      reload_reg <= cfg_reg[`SMBC_CFG_TOE] & pin_in.scl;
    end
  end

  assign reg_rdata      = rdata_reg;
  assign timeout_reload = reload_reg;
  assign pin_out        = '{scl: 1'b0, sda: 1'b0};
  assign pin_oe_n.scl   = ~scl_drv_reg;
  assign pin_oe_n.sda   = ~sda_drv_reg;

endmodule

// [bench/smbc_chk.sv]
// checker of the two-wire bus control block, bound to smbc_core
// assumes it sees only the ports of smbc_core
`timescale 1ns/1ps
`include "smbc_defs.svh"

module smbc_chk
  import smbc_pkg::*;
(
  // clock and reset
  input wire logic                clk_sys,
  input wire logic                sys_rst,
  // register port
  input wire logic [`SMBC_AW-1:0] reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [7:0]          reg_rdata,
  // timers and timeout control
  input wire logic [3:0]          tmr_ovf,
  input wire logic                timeout_reload,
  // bus pins
  input wire smbc_pins_type       pin_in,
  input wire smbc_pins_type       pin_out,
  input wire smbc_pins_type       pin_oe_n
);
  logic [3:0] cfg_reg;
  logic       sta_reg;
  logic       ackw_reg;
  logic       rq_reg;
  logic       crd_reg;
  logic       went_reg;
  logic [4:0] free_reg;
  wire        cfg_wr = reg_wr && reg_addr == `SMBC_ADDR_CFG;
  wire        ctl_wr = reg_wr && reg_addr == `SMBC_ADDR_CTRL;
  wire        ctl_rd = reg_rd && reg_addr == `SMBC_ADDR_CTRL;
  wire        tick   = tmr_ovf[cfg_reg[1:0]];
  wire        rel_in = cfg_reg[3] && pin_in.scl;
  wire        si_vw  = crd_reg && reg_rdata[0];

  // ======================
  // shadow state
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cfg_reg  <= 4'h0;
      sta_reg  <= 1'b0;
      ackw_reg <= 1'b0;
      rq_reg   <= 1'b0;
      crd_reg  <= 1'b0;
      went_reg <= 1'b0;
      free_reg <= 5'h00;
    end
    else
    begin
      crd_reg  <= ctl_rd;
      went_reg <= went_reg || !pin_oe_n.sda;
      if (cfg_wr)
        cfg_reg <= reg_wdata[3:0];
      if (ctl_wr)
        sta_reg <= reg_wdata[5];
      if (ctl_wr)
        ackw_reg <= reg_wdata[1];
      if (ctl_wr && !reg_wdata[0])
        rq_reg <= 1'b0;
      else if (si_vw && reg_rdata[3])
        rq_reg <= 1'b1;
      if (!(pin_in.scl && pin_in.sda))
        free_reg <= 5'h00;
      else if (tick && free_reg != 5'h1f)
        free_reg <= free_reg + 5'h01;
    end
  end

  // ======================
  // properties
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence s_clear_si;
    ctl_wr && !reg_wdata[0];
  endsequence
  sequence s_ack_write;
    ctl_wr && reg_wdata[0] && rq_reg;
  endsequence

  AST_RELOAD:
    assert property (timeout_reload == $past(rel_in))
    else $error("timeout reload does not follow scl");
  AST_CFG_READ:
    assert property (reg_rd && reg_addr == `SMBC_ADDR_CFG
      |=> reg_rdata == {4'h0, cfg_reg})
    else $error("configuration read back wrong");
  AST_STALL:
    assert property (si_vw && reg_rdata[7] && !reg_rdata[2]
      |-> !pin_oe_n.scl || !$past(pin_oe_n.scl))
    else $error("scl not held low with flag set");
  AST_ARB_CLR:
    assert property (s_clear_si ##[1:2] ctl_rd |=> !reg_rdata[2])
    else $error("arbitration flag survives flag clear");
  AST_STA_HOLD:
    assert property (ctl_rd && sta_reg |=> reg_rdata[5])
    else $error("start request dropped by hardware");
  AST_ACK_SDA:
    assert property (s_ack_write |=> ##[0:1] pin_oe_n.sda == !ackw_reg)
    else $error("sda does not follow written ack");
  AST_FREE:
    assert property ($fell(pin_oe_n.sda) && !went_reg
      |-> free_reg > 5'd10)
    else $error("start before bus free");
  AST_RD_IDLE:
    assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  AST_OD_LOW:
    assert property (pin_out == 2'h0)
    else $error("open-drain output not low");
endmodule

bind smbc_core smbc_chk u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .tmr_ovf(tmr_ovf),
  .timeout_reload(timeout_reload), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n)
);

// [bench/smbc_target.sv]
// target model on the two-wire bus: acks its address, sends bytes
// assumes resolved open-drain levels sampled on clk_sys
`timescale 1ns/1ps

module smbc_target #(
  parameter logic [6:0] DEV_ADDR = 7'h2a
)(
  // clock
  clk_sys,
  // resolved bus levels
  scl,
  sda,
  // byte sent on reads, model results
  tx_byte,
  sda_oe_n,
  ack_seen,
  rx_byte
);
  input  wire logic       clk_sys;
  input  wire logic       scl;
  input  wire logic       sda;
  input  wire logic [7:0] tx_byte;
  output logic            sda_oe_n = 1'b1;
  output logic            ack_seen = 1'b1;
  output logic [7:0]      rx_byte  = 8'h00;
  logic       scl_q   = 1'b1;
  logic       sda_q   = 1'b1;
  logic [3:0] bit_cnt = 4'h0;
  logic [7:0] shift   = 8'h00;
  logic       addr_ph = 1'b0;
  logic       hit     = 1'b0;
  logic       rd      = 1'b0;
  wire        send    = hit && rd && !ack_seen;

  always @(posedge clk_sys)
  begin
    scl_q <= scl;
    sda_q <= sda;
    // start or stop: new frame, sda let go
    if (scl_q && scl && sda_q !== sda)
    begin
      bit_cnt  <= 4'h0;
      addr_ph  <= !sda;
      hit      <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else if (!scl_q && scl)
    begin
      if (bit_cnt == 4'h8)
        ack_seen <= sda;
      else
        shift <= {shift[6:0], sda};
      bit_cnt <= bit_cnt + 4'h1;
    end
    else if (scl_q && !scl)
    begin
      sda_oe_n <= 1'b1;
      if (bit_cnt == 4'h8 && addr_ph)
      begin
        hit      <= shift[7:1] == DEV_ADDR;
        rd       <= shift[0];
        sda_oe_n <= shift[7:1] != DEV_ADDR;
      end
      else if (bit_cnt == 4'h8 && hit && !rd)
      begin
        rx_byte  <= shift;
        sda_oe_n <= 1'b0;
      end
      else if (bit_cnt == 4'h9)
      begin
        bit_cnt  <= 4'h0;
        addr_ph  <= 1'b0;
        sda_oe_n <= !send || tx_byte[7];
      end
      else if (bit_cnt < 4'h8 && !addr_ph && send)
        sda_oe_n <= tx_byte[~bit_cnt[2:0]];
    end
  end
endmodule

// [bench/tb_top.sv]
// self-checking bench of the two-wire bus control block
// assumes smbc_core, smbc_target and the bound checker
`timescale 1ns/1ps
`include "smbc_defs.svh"

module tb_top
  import smbc_pkg::*;
;
  localparam logic [6:0] DEV = 7'h2a;
  logic          clk_sys   = 1'b0;
  logic          sys_rst   = 1'b1;
  logic [1:0]    reg_addr  = 2'h0;
  logic [7:0]    reg_wdata = 8'h00;
  logic          reg_wr    = 1'b0;
  logic          reg_rd    = 1'b0;
  logic [7:0]    reg_rdata;
  logic [3:0]    tmr_ovf   = 4'h0;
  logic          timeout_reload;
  smbc_pins_type pin_in;
  smbc_pins_type pin_oe_n;
  logic          t_oe_n;
  logic          ack_seen;
  logic [7:0]    rx_byte;
  logic [7:0]    tx_byte   = 8'h00;
  int            cyc       = 0;
  int            errors    = 0;
  int            checks    = 0;

  always #4 clk_sys = ~clk_sys;
  // open-drain wires with pull-ups
  assign pin_in = {pin_oe_n.scl, pin_oe_n.sda & t_oe_n};
  always @(posedge clk_sys)
  begin
    cyc     <= cyc + 1;
    tmr_ovf <= {cyc % 11 == 0, cyc % 9 == 0, cyc % 7 == 0, cyc % 5 == 0};
  end

  smbc_core dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tmr_ovf(tmr_ovf),
    .timeout_reload(timeout_reload), .pin_in(pin_in), .pin_out(),
    .pin_oe_n(pin_oe_n)
  );
  smbc_target #(.DEV_ADDR(DEV)) peer (
    .clk_sys(clk_sys), .scl(pin_in.scl), .sda(pin_in.sda),
    .tx_byte(tx_byte), .sda_oe_n(t_oe_n), .ack_seen(ack_seen),
    .rx_byte(rx_byte)
  );

  // ======================
  // bus tasks and checks
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk_sys);
  endtask

  task automatic cmp(input logic [7:0] got, exp, mask);
    checks++;
    if ((got & mask) !== (exp & mask))
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // polls control until bit i shows v
  task automatic poll(input int i, input logic v, output logic [7:0] d);
    int n;
    n = 0;
    d = {8{!v}};
    while (d[i] !== v && n < 4000)
    begin
      rd(`SMBC_ADDR_CTRL, d);
      n++;
    end
  endtask

  function automatic logic [7:0] exp_ctl(input logic m, t, s, q, a);
    smbc_ctrl_type c;
    c = '0;
    c.master = m;
    c.tx = t;
    c.begin_request_flag = s;
    c.acknowledge_needed_flag = q;
    c.ack = a;
    c.si = 1'b1;
    return c;
  endfunction

  task automatic begin_addr(input logic [7:0] a, input logic ack);
    logic [7:0] d;
    wr(`SMBC_ADDR_DATA, a);
    wr(`SMBC_ADDR_CTRL, 8'h20);
    poll(0, 1'b1, d);
    cmp(d, exp_ctl(1'b1, 1'b1, 1'b1, 1'b0, 1'b0), 8'he9);
    wr(`SMBC_ADDR_CTRL, 8'h00);
    poll(0, 1'b1, d);
    cmp(d, exp_ctl(1'b1, 1'b0, 1'b0, 1'b0, ack), 8'haf);
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ======================
  // scenarios
  initial
  begin
    logic [7:0] d;
    logic [7:0] b;
    void'($urandom(74));
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    rd(`SMBC_ADDR_CTRL, d);
    cmp(d, `SMBC_CTRL_RST, 8'hff);
    wr(2'h3, 8'hff);
    rd(2'h3, d);
    cmp(d, 8'h00, 8'hff);
    for (int k = 0; k < 4; k++)
    begin
      b = 8'($urandom);
      wr(`SMBC_ADDR_CFG, {b[7:2], k[1:0]});
      rd(`SMBC_ADDR_CFG, d);
      cmp(d, {4'h0, b[3:2], k[1:0]}, 8'hff);
      cmp({7'h0, timeout_reload}, {7'h0, b[3]}, 8'hff);
    end
    b = 8'($urandom);
    wr(`SMBC_ADDR_CFG, {6'h03, b[1:0]});
    begin_addr({DEV, 1'b0}, 1'b1);
    b = 8'($urandom);
    wr(`SMBC_ADDR_DATA, b);
    wr(`SMBC_ADDR_CTRL, 8'h00);
    poll(0, 1'b1, d);
    cmp(d, exp_ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b1), 8'hef);
    cmp(rx_byte, b, 8'hff);
    wr(`SMBC_ADDR_CTRL, 8'h30);
    poll(0, 1'b1, d);
    cmp(d, 8'hf1, 8'hf1);
    wr(`SMBC_ADDR_DATA, {DEV, 1'b0});
    wr(`SMBC_ADDR_CTRL, 8'h10);
    poll(7, 1'b0, d);
    cmp(d, 8'h00, 8'h80);
    cmp({6'h0, pin_oe_n}, 8'h03, 8'hff);
    begin_addr({DEV ^ 7'h01, 1'b0}, 1'b0);
    wr(`SMBC_ADDR_CTRL, 8'h10);
    poll(7, 1'b0, d);
    tx_byte <= 8'($urandom);
    begin_addr({DEV, 1'b1}, 1'b1);
    wr(`SMBC_ADDR_CTRL, 8'h00);
    poll(0, 1'b1, d);
    cmp(d, exp_ctl(1'b1, 1'b0, 1'b0, 1'b1, 1'b0), 8'hc9);
    cmp({7'h0, timeout_reload}, 8'h00, 8'hff);
    rd(`SMBC_ADDR_DATA, d);
    cmp(d, tx_byte, 8'hff);
    wr(`SMBC_ADDR_CTRL, 8'h03);
    #1 cmp({6'h0, pin_oe_n}, 8'h00, 8'hff);
    wr(`SMBC_ADDR_CTRL, 8'h02);
    poll(0, 1'b1, d);
    cmp({7'h0, ack_seen}, 8'h00, 8'hff);
    wr(`SMBC_ADDR_CTRL, 8'h10);
    poll(7, 1'b0, d);
    cmp({7'h0, ack_seen}, 8'h01, 8'hff);
    print_verdict();
  end

  initial
  begin
    repeat (60000) @(posedge clk_sys);
    errors++;
    print_verdict();
  end
endmodule
